// File: kbd_emul_defines.svh
`ifndef KBD_EMUL_DEFINES_SVH
`define KBD_EMUL_DEFINES_SVH

// ==========================================
// register offsets within operational space
`define OFS_CONTROL 12'h100
`define OFS_INPUT 12'h104
`define OFS_OUTPUT 12'h108
`define OFS_STATUS 12'h10C

// ==========================================
// trapped legacy ports and commands
`define PORT_DATA 8'h60
`define PORT_CMD 8'h64
`define CMD_GATE_A20 8'hD1

// ==========================================
// control fields
`define CTL_EE 0
`define CTL_EI 1
`define CTL_CP 2
`define CTL_LEGACY_IRQ_ENABLE 3
`define CTL_EXTIRQ 4
`define CTL_GA20SEQ 5
`define CTL_KBDSEEN 6
`define CTL_AUXSEEN 7
`define CTL_A20 8

// ==========================================
// status fields
`define ST_OUT_FULL 0
`define ST_IN_FULL 1
`define ST_CMD_DATA 3
`define ST_AUX_FULL 5

// ==========================================
// reset values
`define CTL_RST 9'h000
`define BYTE_RST 8'h00

`endif

// File: kbd_emul_pkg.sv
package kbd_emul_pkg;

    // trapped legacy i/o cycle
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] port;
        logic [7:0] data;
    } io_req_s;

    // memory-space register access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } reg_req_s;

endpackage

// File: legacy_keyboard_emulation_regs.sv
// How it works
// - four word registers at 100h, 104h, 108h, 10Ch from operational base
// - port 60h read returns output byte and clears output-full
// - port 60h write loads input byte, sets input-full, clears cmd/data
// - port 64h read returns status and changes nothing
// - port 64h write loads input byte, clears input-full, sets cmd/data
// - control bit 8 holds gate A20 state, compared on 60h write
// - bit 7 set on aux irq rise; writing 1 quiets mouse line
// - bit 6 set on kbd irq rise; writing 1 quiets keyboard line
// - bit 5 set by D1h written to 64h, cleared by other values
// - bit 4 lets keyboard controller irqs raise emulation interrupt
// - bit 3 with output-full drives keyboard or mouse line by aux flag
// - bit 2 raises emulation interrupt when output-full falls
// - bit 1 reports the emulation interrupt condition
// - bit 0 enables port decode, legacy lines and the trap and output-full-fall emulation interrupts, not the bit 4 ones
// - memory accesses to registers have no flag side effects
`timescale 1ns/1ps
`default_nettype none
`include "kbd_emul_defines.svh"

module legacy_keyboard_emulation_regs
    import kbd_emul_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire io_req_s io_req_i,
    output logic io_claim_o,
    output logic io_ack_o,
    output logic [7:0] io_rdata_o,
    input wire reg_req_s reg_req_i,
    output logic reg_rvalid_o,
    output logic [31:0] reg_rdata_o,
    input wire logic kbd_irq_i,
    input wire logic aux_irq_i,
    output logic keyboard_interrupt_line_o,
    output logic mouse_interrupt_line_o,
    output logic emulation_irq_o
);

    // ==========================================
    // state
    logic [8:0] ctl_reg;
    logic [8:0] ctl_next;
    logic [7:0] in_reg;
    logic [7:0] in_next;
    logic [7:0] out_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic kbd_prev_reg;
    logic aux_prev_reg;
    logic of_prev_reg;
    logic kbd_mute_reg;
    logic kbd_mute_next;
    logic aux_mute_reg;
    logic aux_mute_next;
    logic kbd_line_reg;
    logic aux_line_reg;
    logic io_ack_reg;
    logic [7:0] io_rdata_reg;
    logic reg_rvalid_reg;
    logic [31:0] reg_rdata_reg;

    // ==========================================
    // i/o trap decode
    wire emu_on = ctl_reg[`CTL_EE];
    wire is60 = (io_req_i.port == `PORT_DATA);
    wire is64 = (io_req_i.port == `PORT_CMD);
    // decode only while enabled, so a disabled block stays invisible
    wire io_hit = io_req_i.valid & emu_on & (is60 | is64);
    wire rd60 = io_hit & ~io_req_i.write & is60;
    wire wr60 = io_hit & io_req_i.write & is60;
    wire rd64 = io_hit & ~io_req_i.write & is64;
    wire wr64 = io_hit & io_req_i.write & is64;

    // ==========================================
    // memory decode
    wire sel_ctl = (reg_req_i.addr == `OFS_CONTROL);
    wire sel_in = (reg_req_i.addr == `OFS_INPUT);
    wire sel_out = (reg_req_i.addr == `OFS_OUTPUT);
    wire sel_st = (reg_req_i.addr == `OFS_STATUS);
    wire wr_ctl = reg_req_i.wr & sel_ctl;
    wire wr_in = reg_req_i.wr & sel_in;
    wire wr_out = reg_req_i.wr & sel_out;
    wire wr_st = reg_req_i.wr & sel_st;
    wire [31:0] wd = reg_req_i.wdata;

    // ==========================================
    // event detection
    wire kbd_rise = kbd_irq_i & ~kbd_prev_reg;
    wire aux_rise = aux_irq_i & ~aux_prev_reg;
    wire of_fall = of_prev_reg & ~status_reg[`ST_OUT_FULL];
    wire of_rise = ~of_prev_reg & status_reg[`ST_OUT_FULL];
    // matching A20 value needs no software help
    wire a20_match = ctl_reg[`CTL_GA20SEQ] &
        (io_req_i.data[1] == ctl_reg[`CTL_A20]);
    wire ext_evt = ctl_reg[`CTL_EXTIRQ] & (kbd_rise | aux_rise);
    wire cp_evt = emu_on & ctl_reg[`CTL_CP] & of_fall;
    wire io_evt = wr64 | (wr60 & ~a20_match);
    wire ei_set = ext_evt | cp_evt | io_evt;

    // ==========================================
    // control next value
    always_comb begin
        ctl_next = ctl_reg;
        if (wr_ctl) begin
            // reserved bits are not stored and read back as zero
            ctl_next[`CTL_EE] = wd[`CTL_EE];
            ctl_next[`CTL_EI] = wd[`CTL_EI];
            ctl_next[`CTL_CP] = wd[`CTL_CP];
            ctl_next[`CTL_LEGACY_IRQ_ENABLE] = wd[`CTL_LEGACY_IRQ_ENABLE];
            ctl_next[`CTL_EXTIRQ] = wd[`CTL_EXTIRQ];
            ctl_next[`CTL_GA20SEQ] = wd[`CTL_GA20SEQ];
            ctl_next[`CTL_A20] = wd[`CTL_A20];
            if (wd[`CTL_KBDSEEN]) begin
                ctl_next[`CTL_KBDSEEN] = 1'b0;
            end
            if (wd[`CTL_AUXSEEN]) begin
                ctl_next[`CTL_AUXSEEN] = 1'b0;
            end
        end
        if (wr64) begin
            ctl_next[`CTL_GA20SEQ] =
                (io_req_i.data == `CMD_GATE_A20);
        end
        // hardware sets beat software clears in the same cycle
        if (kbd_rise) begin
            ctl_next[`CTL_KBDSEEN] = 1'b1;
        end
        if (aux_rise) begin
            ctl_next[`CTL_AUXSEEN] = 1'b1;
        end
        if (ei_set) begin
            ctl_next[`CTL_EI] = 1'b1;
        end
    end

    // ==========================================
    // status and input next values
    always_comb begin
        status_next = status_reg;
        in_next = in_reg;
        if (rd60) begin
            status_next[`ST_OUT_FULL] = 1'b0;
        end
        if (wr60) begin
            in_next = io_req_i.data;
            status_next[`ST_IN_FULL] = 1'b1;
            status_next[`ST_CMD_DATA] = 1'b0;
        end
        if (wr64) begin
            in_next = io_req_i.data;
            status_next[`ST_IN_FULL] = 1'b0;
            status_next[`ST_CMD_DATA] = 1'b1;
        end
        // plain stores; a software load of a new byte wins
        if (wr_st) begin
            status_next = wd[7:0];
        end
        if (wr_in) begin
            in_next = wd[7:0];
        end
    end

    // ==========================================
    // line mute after software acknowledge
    always_comb begin
        kbd_mute_next = kbd_mute_reg;
        aux_mute_next = aux_mute_reg;
        if (wr_ctl && wd[`CTL_KBDSEEN]) begin
            kbd_mute_next = 1'b1;
        end
        if (wr_ctl && wd[`CTL_AUXSEEN]) begin
            aux_mute_next = 1'b1;
        end
        // a fresh byte or a fresh edge rearms the line
        if (of_rise || kbd_rise) begin
            kbd_mute_next = 1'b0;
        end
        if (of_rise || aux_rise) begin
            aux_mute_next = 1'b0;
        end
    end

    // ==========================================
    // legacy line generation
    wire line_base = emu_on & ctl_reg[`CTL_LEGACY_IRQ_ENABLE] &
        status_reg[`ST_OUT_FULL];
    wire kbd_line_next = line_base & ~status_reg[`ST_AUX_FULL] &
        ~kbd_mute_reg;
    wire aux_line_next = line_base & status_reg[`ST_AUX_FULL] &
        ~aux_mute_reg;

    // ==========================================
    // read muxes
    wire [31:0] reg_rd_mux =
        sel_ctl ? {23'h0, ctl_reg} :
        sel_in ? {24'h000000, in_reg} :
        sel_out ? {24'h000000, out_reg} :
        sel_st ? {24'h000000, status_reg} :
        32'h00000000;
    wire [7:0] io_rd_mux = is60 ? out_reg : status_reg;

    // ==========================================
    // registers
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_reg <= `CTL_RST;
            in_reg <= `BYTE_RST;
            out_reg <= `BYTE_RST;
            status_reg <= `BYTE_RST;
        end else begin
            ctl_reg <= ctl_next;
            in_reg <= in_next;
            status_reg <= status_next;
            if (wr_out) begin
                out_reg <= wd[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            kbd_prev_reg <= 1'b0;
            aux_prev_reg <= 1'b0;
            of_prev_reg <= 1'b0;
            kbd_mute_reg <= 1'b0;
            aux_mute_reg <= 1'b0;
            kbd_line_reg <= 1'b0;
            aux_line_reg <= 1'b0;
        end else begin
            kbd_prev_reg <= kbd_irq_i;
            aux_prev_reg <= aux_irq_i;
            of_prev_reg <= status_reg[`ST_OUT_FULL];
            kbd_mute_reg <= kbd_mute_next;
            aux_mute_reg <= aux_mute_next;
            kbd_line_reg <= kbd_line_next;
            aux_line_reg <= aux_line_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            io_ack_reg <= 1'b0;
            io_rdata_reg <= `BYTE_RST;
            reg_rvalid_reg <= 1'b0;
            reg_rdata_reg <= 32'h00000000;
        end else begin
            io_ack_reg <= io_hit;
            io_rdata_reg <= io_rd_mux;
            reg_rvalid_reg <= reg_req_i.rd;
            reg_rdata_reg <= reg_rd_mux;
        end
    end

    // ==========================================
    // outputs
    assign io_claim_o = io_hit;
    assign io_ack_o = io_ack_reg;
    assign io_rdata_o = io_rdata_reg;
    assign reg_rvalid_o = reg_rvalid_reg;
    assign reg_rdata_o = reg_rdata_reg;
    assign keyboard_interrupt_line_o = kbd_line_reg;
    assign mouse_interrupt_line_o = aux_line_reg;
    assign emulation_irq_o = ctl_reg[`CTL_EI];

    // ==========================================
    // assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    property p_rd60;
        rd60 && !wr_st |=> !status_reg[`ST_OUT_FULL] && io_ack_o &&
            io_rdata_o == $past(out_reg);
    endproperty
    a_rd60: assert property (p_rd60)
        else $error("port 60h read wrong");

    property p_wr60;
        wr60 && !wr_st && !wr_in |=> status_reg[`ST_IN_FULL] &&
            !status_reg[`ST_CMD_DATA] && in_reg == $past(io_req_i.data);
    endproperty
    a_wr60: assert property (p_wr60)
        else $error("port 60h write wrong");

    property p_rd64;
        rd64 && !reg_req_i.wr |=> $stable(status_reg) && $stable(in_reg)
            && io_rdata_o == $past(status_reg);
    endproperty
    a_rd64: assert property (p_rd64)
        else $error("port 64h read changed state");

    property p_wr64;
        wr64 && !wr_st && !wr_in |=> !status_reg[`ST_IN_FULL] &&
            status_reg[`ST_CMD_DATA] && in_reg == $past(io_req_i.data);
    endproperty
    a_wr64: assert property (p_wr64)
        else $error("port 64h write wrong");

    property p_ga20;
        wr64 |=> ctl_reg[`CTL_GA20SEQ] ==
            ($past(io_req_i.data) == `CMD_GATE_A20);
    endproperty
    a_ga20: assert property (p_ga20)
        else $error("gate A20 sequence flag wrong");

    property p_kbd_seen;
        kbd_irq_i && !kbd_prev_reg |=> ctl_reg[`CTL_KBDSEEN];
    endproperty
    a_kbd_seen: assert property (p_kbd_seen)
        else $error("kbd irq edge lost");

    property p_aux_seen;
        $rose(aux_irq_i) |=> ctl_reg[`CTL_AUXSEEN];
    endproperty
    a_aux_seen: assert property (p_aux_seen)
        else $error("aux irq edge lost");

    property p_line;
        ##1 keyboard_interrupt_line_o |-> $past(emu_on) &&
            $past(ctl_reg[`CTL_LEGACY_IRQ_ENABLE]) && $past(status_reg[`ST_OUT_FULL])
            && !$past(status_reg[`ST_AUX_FULL]) && !mouse_interrupt_line_o;
    endproperty
    a_line: assert property (p_line)
        else $error("keyboard line without cause");

    property p_ext;
        ctl_reg[`CTL_EXTIRQ] && (kbd_rise || aux_rise) |=> emulation_irq_o;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external irq not forwarded");

    property p_cp;
        emu_on && ctl_reg[`CTL_CP] && of_fall |=> emulation_irq_o;
    endproperty
    a_cp: assert property (p_cp)
        else $error("character pending irq missed");

    property p_off;
        !emu_on && !reg_req_i.wr |-> !io_claim_o ##1
            (!io_ack_o && $stable(status_reg) && $stable(in_reg));
    endproperty
    a_off: assert property (p_off)
        else $error("claim while disabled");

    property p_mem_quiet;
        (wr_in || wr_out) && !io_hit && !wr_st |=> $stable(status_reg);
    endproperty
    a_mem_quiet: assert property (p_mem_quiet)
        else $error("memory access touched flags");

    c_rd60: cover property (rd60 ##1 io_ack_o);
    c_ga20: cover property (wr64 && io_req_i.data == `CMD_GATE_A20
        ##[1:20] wr60);
    c_line: cover property (keyboard_interrupt_line_o ##[1:20]
        mouse_interrupt_line_o);

endmodule
`default_nettype wire

// File: legacy_sw_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// legacy software issuing trapped port cycles
module legacy_sw_model
    import kbd_emul_pkg::*;
(
    input wire logic clk_sys_i,
    output var io_req_s io_req_o,
    input wire logic io_claim_i,
    input wire logic io_ack_i,
    input wire logic [7:0] io_rdata_i
);
    initial io_req_o = '{valid: 1'b0, write: 1'b0, port: 8'h00, data: 8'h00};

    // one byte per cycle; released lines carry inverted junk, not old data
    task automatic io_cycle(input logic wr, input logic [7:0] port,
        input logic [7:0] data, output logic claimed, output logic acked,
        output logic [7:0] rdata);
        @(posedge clk_sys_i);
        #1;
        io_req_o = '{valid: 1'b1, write: wr, port: port, data: data};
        #1;
        claimed = io_claim_i;
        @(posedge clk_sys_i);
        #1;
        acked = io_ack_i;
        rdata = io_rdata_i;
        io_req_o = '{valid: 1'b0, write: wr, port: ~port, data: ~data};
    endtask
endmodule

`default_nettype wire

// File: legacy_keyboard_emulation_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    n_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end end

module legacy_keyboard_emulation_regs_test
    import kbd_emul_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    io_req_s io_req;
    reg_req_s reg_req = '0;
    logic kbd_irq = 1'b0;
    logic aux_irq = 1'b0;
    logic io_claim, io_ack, reg_rvalid, kbd_line, mouse_line, emu_irq;
    logic [7:0] io_rdata;
    logic [31:0] reg_rdata;
    logic claimed, acked;
    logic [7:0] rd8;
    int n_errors = 0;
    int n_tests = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    legacy_keyboard_emulation_regs DUT (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .io_req_i(io_req), .io_claim_o(io_claim), .io_ack_o(io_ack),
        .io_rdata_o(io_rdata), .reg_req_i(reg_req),
        .reg_rvalid_o(reg_rvalid), .reg_rdata_o(reg_rdata),
        .kbd_irq_i(kbd_irq), .aux_irq_i(aux_irq),
        .keyboard_interrupt_line_o(kbd_line),
        .mouse_interrupt_line_o(mouse_line),
        .emulation_irq_o(emu_irq)
    );

    legacy_sw_model sw (
        .clk_sys_i(clk_sys_i), .io_req_o(io_req), .io_claim_i(io_claim),
        .io_ack_i(io_ack), .io_rdata_i(io_rdata)
    );

    // ==========================================
    // access tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // reserved bits always sent as zero
    task automatic reg_wr(input logic [11:0] addr, input logic [31:0] data);
        @(posedge clk_sys_i);
        #1;
        reg_req = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(posedge clk_sys_i);
        #1;
        reg_req.wr = 1'b0;
    endtask

    task automatic reg_chk(input logic [11:0] addr, input logic [31:0] exp);
        @(posedge clk_sys_i);
        #1;
        reg_req = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 32'h0};
        @(posedge clk_sys_i);
        #1;
        reg_req.rd = 1'b0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, exp)
    endtask

    task automatic io_do(input logic wr, input logic [7:0] port,
        input logic [7:0] data, input logic claim_exp,
        input logic [7:0] rdata_exp);
        sw.io_cycle(wr, port, data, claimed, acked, rd8);
        `CHK(claimed, claim_exp)
        `CHK(acked, claim_exp)
        if (!wr && claim_exp) `CHK(rd8, rdata_exp)
    endtask

    task automatic final_report();
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ==========================================
    // watchdog: whole sequence needs well under 2 us
    initial begin
        #20000;
        n_errors++;
        final_report();
    end

    // ==========================================
    // tests
    initial begin
        repeat (2) @(posedge clk_sys_i);
        #1;
        resetn_i = 1'b1;
        for (int a = 0; a < 5; a++) begin
            reg_chk(12'h100 + 12'(a * 4), 32'h0);
        end
        // emulation off: cycle ignored, nothing captured
        io_do(1'b1, 8'h60, 8'h77, 1'b0, 8'h00);
        reg_chk(12'h104, 32'h0);
        reg_wr(12'h108, 32'hA5);
        reg_wr(12'h10C, 32'h01);
        reg_wr(12'h100, 32'h001);
        reg_chk(12'h10C, 32'h01);
        reg_chk(12'h10C, 32'h01);
        reg_chk(12'h108, 32'hA5);
        io_do(1'b0, 8'h64, 8'h00, 1'b1, 8'h01);
        reg_chk(12'h10C, 32'h01);
        io_do(1'b0, 8'h60, 8'h00, 1'b1, 8'hA5);
        reg_chk(12'h10C, 32'h00);
        io_do(1'b1, 8'h60, 8'h3C, 1'b1, 8'h00);
        reg_chk(12'h104, 32'h3C);
        reg_chk(12'h10C, 32'h02);
        reg_chk(12'h100, 32'h003);
        `CHK(emu_irq, 1'b1)
        reg_wr(12'h100, 32'h001);
        io_do(1'b1, 8'h64, 8'hD1, 1'b1, 8'h00);
        reg_chk(12'h104, 32'hD1);
        reg_chk(12'h10C, 32'h08);
        reg_chk(12'h100, 32'h023);
        io_do(1'b1, 8'h64, 8'h55, 1'b1, 8'h00);
        reg_chk(12'h100, 32'h003);
        // gate sequence armed with state high: match keeps irq quiet
        reg_wr(12'h100, 32'h121);
        io_do(1'b1, 8'h60, 8'h02, 1'b1, 8'h00);
        reg_chk(12'h100, 32'h121);
        io_do(1'b1, 8'h60, 8'h00, 1'b1, 8'h00);
        reg_chk(12'h100, 32'h123);
        // legacy lines follow output-full and the aux flag
        reg_wr(12'h10C, 32'h01);
        reg_wr(12'h100, 32'h008);
        tick(2);
        `CHK(kbd_line, 1'b0)
        reg_wr(12'h100, 32'h009);
        tick(2);
        `CHK(kbd_line, 1'b1)
        `CHK(mouse_line, 1'b0)
        reg_wr(12'h10C, 32'h21);
        tick(2);
        `CHK(kbd_line, 1'b0)
        `CHK(mouse_line, 1'b1)
        // character pending: draining the output byte interrupts
        reg_wr(12'h10C, 32'h01);
        reg_wr(12'h100, 32'h005);
        io_do(1'b0, 8'h60, 8'h00, 1'b1, 8'hA5);
        tick(2);
        reg_chk(12'h100, 32'h007);
        // external irqs with emulation off
        reg_wr(12'h100, 32'h010);
        kbd_irq = 1'b1;
        tick(3);
        reg_chk(12'h100, 32'h052);
        `CHK(emu_irq, 1'b1)
        aux_irq = 1'b1;
        tick(3);
        reg_chk(12'h100, 32'h0D2);
        reg_wr(12'h100, 32'h0D0);
        reg_chk(12'h100, 32'h010);
        kbd_irq = 1'b0;
        aux_irq = 1'b0;
        tick(2);
        // fresh output byte rearms the lines; writing 1 to a seen bit mutes
        reg_wr(12'h10C, 32'h01);
        reg_wr(12'h100, 32'h009);
        tick(2);
        `CHK(kbd_line, 1'b1)
        reg_wr(12'h100, 32'h049);
        tick(2);
        `CHK(kbd_line, 1'b0)
        reg_wr(12'h10C, 32'h21);
        tick(2);
        `CHK(mouse_line, 1'b1)
        reg_wr(12'h100, 32'h089);
        tick(2);
        `CHK(mouse_line, 1'b0)
        final_report();
    end
endmodule

`undef CHK
`default_nettype wire
